// ===== period_match_timer.sv
// top of the period match timer: registers, counter, compare, flag, interrupt
// assumes i_clk is the oscillator; instruction ticks are made here by dividing by four
//
// The plain strobed port and the address map were decided locally.
`include "period_match_timer_defines.svh"

module period_match_timer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // register port
    input period_match_timer_pkg::bus_req_s i_bus,
    output period_match_timer_pkg::byte_t o_rdata,
    // events
    output logic o_match,
    output logic o_irq
);

    logic [1:0] div_r;
    logic inst_tick;
    period_match_timer_pkg::byte_t count_r;
    period_match_timer_pkg::byte_t count_nxt;
    period_match_timer_pkg::byte_t period_r;
    period_match_timer_pkg::byte_t control_r;
    logic flag_r;
    logic irq_en_r;
    logic wr_count;
    logic wr_period;
    logic wr_control;
    logic wr_flags;
    logic wr_irq_en;
    logic scaler_clr;
    logic timer_on;
    logic pre_tick;
    logic match_c;
    logic post_event;

    // write decode
    assign wr_count = i_bus.wr && (i_bus.addr == `PMT_ADDR_COUNT);
    assign wr_period = i_bus.wr && (i_bus.addr == `PMT_ADDR_PERIOD);
    assign wr_control = i_bus.wr && (i_bus.addr == `PMT_ADDR_CONTROL);
    assign wr_flags = i_bus.wr && (i_bus.addr == `PMT_ADDR_FLAGS);
    assign wr_irq_en = i_bus.wr && (i_bus.addr == `PMT_ADDR_IRQ_EN);
    assign scaler_clr = wr_count || wr_control;
    assign timer_on = control_r[`PMT_CTL_ON_BIT];

    // free-running divide by four for the instruction clock
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_r <= 2'h0;
        end else begin
            div_r <= (div_r == `PMT_OSC_PER_INST) ? 2'h0 : div_r + 2'h1;
        end
    end
    assign inst_tick = (div_r == `PMT_OSC_PER_INST);

    // prescaler only runs while the timer is on
    pmt_prescaler u_pre (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_en(inst_tick && timer_on),
        .i_clr(scaler_clr),
        .i_sel(control_r[`PMT_CTL_PRE_MSB:`PMT_CTL_PRE_LSB]),
        .o_tick(pre_tick)
    );

    // compare on every cycle; a match only counts on a tick
    assign match_c = pre_tick && (count_r == period_r);

    // next count: software write wins, then wrap on match, else step
    always_comb begin
        count_nxt = count_r; // control writes leave the count here
        if (wr_count) begin
            count_nxt = i_bus.wdata;
        end else if (pre_tick) begin
            count_nxt = match_c ? `PMT_RST_COUNT : count_r + 8'h01;
        end
    end

    // timer count register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_r <= `PMT_RST_COUNT;
        end else begin
            count_r <= count_nxt;
        end
    end

    // period register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            period_r <= `PMT_RST_PERIOD;
        end else if (wr_period) begin
            period_r <= i_bus.wdata;
        end
    end

    // control register, bit 7 not stored
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            control_r <= `PMT_RST_CONTROL;
        end else if (wr_control) begin
            control_r <= i_bus.wdata & `PMT_CTL_IMPL_MASK;
        end
    end

    // postscaler fed by the unscaled match
    pmt_postscaler u_post (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_match(match_c),
        .i_clr(scaler_clr),
        .i_sel(control_r[`PMT_CTL_POST_MSB:`PMT_CTL_POST_LSB]),
        .o_event(post_event)
    );

    // unscaled match output for other peripherals
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_match <= 1'b0;
        end else begin
            o_match <= match_c;
        end
    end

    // sticky match event flag, a new event beats a write-one clear
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flag_r <= 1'b0;
        end else if (post_event) begin
            flag_r <= 1'b1;
        end else if (wr_flags && i_bus.wdata[`PMT_FLAG_MATCH_BIT]) begin
            flag_r <= 1'b0;
        end
    end

    // interrupt enable register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_en_r <= 1'b0;
        end else if (wr_irq_en) begin
            irq_en_r <= i_bus.wdata[`PMT_FLAG_MATCH_BIT];
        end
    end

    // interrupt level, gated by the enable
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= flag_r && irq_en_r;
        end
    end

    // read data, valid the cycle after the read strobe
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else if (i_bus.rd) begin
            case (i_bus.addr)
                `PMT_ADDR_COUNT: o_rdata <= count_r;
                `PMT_ADDR_PERIOD: o_rdata <= period_r;
                `PMT_ADDR_CONTROL: o_rdata <= control_r & `PMT_CTL_IMPL_MASK;
                `PMT_ADDR_FLAGS: o_rdata <= 8'(flag_r) << `PMT_FLAG_MATCH_BIT;
                `PMT_ADDR_IRQ_EN: o_rdata <= 8'(irq_en_r) << `PMT_FLAG_MATCH_BIT;
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // checks on counting, match pulse, period write, control read, flag, reset values and scaler clears
    property p_step;
        @(posedge i_clk) disable iff (!i_rst_b)
            (pre_tick && !match_c && !wr_count) |=> count_r == $past(count_r) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("count did not step on tick");

    property p_wrap;
        @(posedge i_clk) disable iff (!i_rst_b) (match_c && !wr_count) |=> count_r == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count not reloaded after match");

    property p_match_out;
        @(posedge i_clk) disable iff (!i_rst_b)
            o_match |-> ($past(count_r) == $past(period_r) && $past(pre_tick));
    endproperty
    a_match_out: assert property (p_match_out) else $error("match pulse without equal compare");

    property p_ctl_keeps_count;
        @(posedge i_clk) disable iff (!i_rst_b) (wr_control && !wr_count) |=> count_r == $past(count_r);
    endproperty
    a_ctl_keeps_count: assert property (p_ctl_keeps_count) else $error("control write moved count");

    property p_off_holds;
        @(posedge i_clk) disable iff (!i_rst_b)
            (!timer_on && !wr_count) |=> (count_r == $past(count_r) && !o_match);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("timer moved while off");

    property p_on_counts;
        @(posedge i_clk) disable iff (!i_rst_b)
            (timer_on && control_r[1:0] == 2'h0 && inst_tick && !scaler_clr) |-> pre_tick;
    endproperty
    a_on_counts: assert property (p_on_counts) else $error("enabled timer missed a tick");

    property p_period_wr;
        @(posedge i_clk) disable iff (!i_rst_b) wr_period |=> period_r == $past(i_bus.wdata);
    endproperty
    a_period_wr: assert property (p_period_wr) else $error("period write lost");

    property p_ctl_bit7;
        @(posedge i_clk) disable iff (!i_rst_b) $past(i_bus.rd) |-> !o_rdata[7] || $past(i_bus.addr) < 3'h2;
    endproperty
    a_ctl_bit7: assert property (p_ctl_bit7) else $error("control bit 7 read as one");

    property p_flag_set;
        @(posedge i_clk) disable iff (!i_rst_b) post_event |=> flag_r ##1 (o_irq == irq_en_r || $past(wr_irq_en));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event flag or interrupt wrong");

    property p_reset_values;
        @(posedge i_clk) $rose(i_rst_b) |-> (count_r == 8'h00 && period_r == 8'hff);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

    property p_write_clears;
        @(posedge i_clk) disable iff (!i_rst_b) scaler_clr |-> !pre_tick && !post_event;
    endproperty
    a_write_clears: assert property (p_write_clears) else $error("scaler advanced on clearing write");

    // checks on the divider, registers, read port, flag and interrupt
    property p_inst_rate;
        @(posedge i_clk) disable iff (!i_rst_b)
            inst_tick |=> !inst_tick ##1 !inst_tick ##1 !inst_tick ##1 inst_tick;
    endproperty
    a_inst_rate: assert property (p_inst_rate) else $error("instruction tick not every fourth clock");

    property p_count_wr;
        @(posedge i_clk) disable iff (!i_rst_b)
            wr_count |=> count_r == $past(i_bus.wdata);
    endproperty
    a_count_wr: assert property (p_count_wr) else $error("count write lost");

    property p_period_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
            !wr_period |=> period_r == $past(period_r);
    endproperty
    a_period_hold: assert property (p_period_hold) else $error("period changed without a write");

    property p_ctl_wr;
        @(posedge i_clk) disable iff (!i_rst_b)
            wr_control |=> control_r == ($past(i_bus.wdata) & `PMT_CTL_IMPL_MASK);
    endproperty
    a_ctl_wr: assert property (p_ctl_wr) else $error("control write stored wrong");

    property p_ctl_top_zero;
        @(posedge i_clk) disable iff (!i_rst_b)
            !control_r[7];
    endproperty
    a_ctl_top_zero: assert property (p_ctl_top_zero) else $error("control bit 7 stored");

    property p_match_single;
        @(posedge i_clk) disable iff (!i_rst_b)
            o_match |=> !o_match;
    endproperty
    a_match_single: assert property (p_match_single) else $error("match pulse longer than one cycle");

    property p_match_needs_on;
        @(posedge i_clk) disable iff (!i_rst_b)
            o_match |-> $past(timer_on);
    endproperty
    a_match_needs_on: assert property (p_match_needs_on) else $error("match pulse while timer off");

    property p_rdata_idle;
        @(posedge i_clk) disable iff (!i_rst_b)
            !$past(i_bus.rd) |-> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

    property p_count_read;
        @(posedge i_clk) disable iff (!i_rst_b)
            ($past(i_bus.rd) && $past(i_bus.addr) == `PMT_ADDR_COUNT) |-> o_rdata == $past(count_r);
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read back wrong");

    property p_flag_clear;
        @(posedge i_clk) disable iff (!i_rst_b)
            (wr_flags && i_bus.wdata[`PMT_FLAG_MATCH_BIT] && !post_event) |=> !flag_r;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("event flag not cleared by write one");

    property p_flag_sticky;
        @(posedge i_clk) disable iff (!i_rst_b)
            (flag_r && !(wr_flags && i_bus.wdata[`PMT_FLAG_MATCH_BIT])) |=> flag_r;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("event flag dropped by itself");

    property p_flag_cause;
        @(posedge i_clk) disable iff (!i_rst_b)
            $rose(flag_r) |-> $past(post_event);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("event flag set without postscale event");

    property p_irq_level;
        @(posedge i_clk) disable iff (!i_rst_b)
            o_irq == ($past(flag_r) && $past(irq_en_r));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

endmodule

// ===== period_match_timer_defines.svh
// offsets, field positions, reset values and counts of the period match timer
// assumes a register port with a 3-bit word address and 8-bit data
// What this block does
// - count up from zero on prescaled ticks
// - prescale select picks divide by 1, 4, 16
// - compare count with period, pulse on match
// - match reloads count with zero next cycle
// - postscaler divides matches by select plus one
// - reset clears count, period becomes all ones
// - count or control write clears both scalers
// - control write leaves count unchanged
// - timer-on bit enables counting, clear stops it
// - count and period readable, writable any time
// - control bit 7 reads zero, fields reset zero
// - postscaler event sets flag, enable gates interrupt
`ifndef PERIOD_MATCH_TIMER_DEFINES_SVH
`define PERIOD_MATCH_TIMER_DEFINES_SVH

// register word addresses
`define PMT_ADDR_COUNT 3'h0
`define PMT_ADDR_PERIOD 3'h1
`define PMT_ADDR_CONTROL 3'h2
`define PMT_ADDR_FLAGS 3'h3
`define PMT_ADDR_IRQ_EN 3'h4

// control register fields
`define PMT_CTL_PRE_LSB 0
`define PMT_CTL_PRE_MSB 1
`define PMT_CTL_ON_BIT 2
`define PMT_CTL_POST_LSB 3
`define PMT_CTL_POST_MSB 6
`define PMT_CTL_IMPL_MASK 8'h7f

// flag and enable register field
`define PMT_FLAG_MATCH_BIT 1

// reset values
`define PMT_RST_COUNT 8'h00
`define PMT_RST_PERIOD 8'hff
`define PMT_RST_CONTROL 8'h00

// last divider count of each four-clock instruction cycle
`define PMT_OSC_PER_INST 2'h3

// prescale terminal counts
`define PMT_PRE_LAST_1 4'h0
`define PMT_PRE_LAST_4 4'h3
`define PMT_PRE_LAST_16 4'hf

`endif

// ===== period_match_timer_pkg.sv
// types shared by the period match timer files
// assumes nothing beyond a SystemVerilog compiler
package period_match_timer_pkg;

    typedef logic [7:0] byte_t;

    // one register port request
    typedef struct packed {
        logic [2:0] addr;
        byte_t wdata;
        logic wr;
        logic rd;
    } bus_req_s;

endpackage

// ===== pmt_prescaler.sv
// prescaler of the period match timer: 4-bit counter on instruction ticks
// assumes i_en is a one-cycle instruction tick already gated by timer-on
`include "period_match_timer_defines.svh"

module pmt_prescaler (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // control
    input wire logic i_en,
    input wire logic i_clr,
    input wire logic [1:0] i_sel,
    // prescaled tick
    output logic o_tick
);

    logic [3:0] cnt_r;
    logic [3:0] last;

    // terminal count for the selected ratio
    function automatic logic [3:0] pre_last(input logic [1:0] sel);
        case (sel)
            2'h0: pre_last = `PMT_PRE_LAST_1;
            2'h1: pre_last = `PMT_PRE_LAST_4;
            default: pre_last = `PMT_PRE_LAST_16;
        endcase
    endfunction

    assign last = pre_last(i_sel);
    // a clear suppresses the tick of that cycle
    assign o_tick = i_en && !i_clr && (cnt_r >= last);

    // prescale counter
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r <= 4'h0;
        end else if (i_clr) begin
            cnt_r <= 4'h0;
        end else if (i_en) begin
            cnt_r <= (cnt_r >= last) ? 4'h0 : cnt_r + 4'h1;
        end
    end

    property p_pre_clear;
        @(posedge i_clk) disable iff (!i_rst_b) i_clr |=> cnt_r == 4'h0;
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

    property p_pre_ratio;
        @(posedge i_clk) disable iff (!i_rst_b) (i_sel == 2'h1 && o_tick) |-> cnt_r == 4'h3;
    endproperty
    a_pre_ratio: assert property (p_pre_ratio) else $error("divide by 4 tick at wrong count");

endmodule

// ===== pmt_postscaler.sv
// postscaler of the period match timer: counts match pulses
// assumes i_match is a one-cycle pulse on the block clock
module pmt_postscaler (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // control
    input wire logic i_match,
    input wire logic i_clr,
    input wire logic [3:0] i_sel,
    // scaled event
    output logic o_event
);

    logic [3:0] cnt_r;

    // event on the match that completes the selected count
    assign o_event = i_match && !i_clr && (cnt_r >= i_sel);

    // postscale counter
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r <= 4'h0;
        end else if (i_clr) begin
            cnt_r <= 4'h0;
        end else if (i_match) begin
            cnt_r <= (cnt_r >= i_sel) ? 4'h0 : cnt_r + 4'h1;
        end
    end

    property p_post_count;
        @(posedge i_clk) disable iff (!i_rst_b) o_event |-> cnt_r == i_sel;
    endproperty
    a_post_count: assert property (p_post_count) else $error("postscale event at wrong count");

    property p_post_clear;
        @(posedge i_clk) disable iff (!i_rst_b) i_clr |=> cnt_r == 4'h0;
    endproperty
    a_post_clear: assert property (p_post_clear) else $error("postscaler not cleared");

endmodule

// ===== period_match_timer_tb.sv
// self-checking bench for the period match timer: register port, counting, scalers, flag, interrupt
// assumes the design files and the defines header are compiled first; one 20 MHz clock
`include "period_match_timer_defines.svh"

module period_match_timer_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    period_match_timer_pkg::bus_req_s i_bus = '0;
    period_match_timer_pkg::byte_t o_rdata;
    logic o_match;
    logic o_irq;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;

    // device under test
    period_match_timer u_period_match_timer (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_bus(i_bus),
        .o_rdata(o_rdata),
        .o_match(o_match),
        .o_irq(o_irq)
    );

    // 50 ns clock
    always #25 i_clk = ~i_clk;

    // hang guard: the run needs a few thousand cycles at most
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle write strobe, then idle again
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus <= '0;
    endtask

    // one-cycle read strobe; data stands only in the following cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus <= '0;
        #1;
        d = o_rdata;
    endtask

    // clock edges until the next match pulse
    task automatic wait_match(output int n);
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (o_match !== 1'b1 && n < 1000);
    endtask

    // reset values of every address, unmapped ones read zero
    task automatic reset_values();
        logic [7:0] d;
        logic [7:0] exp [8] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d);
            check("reset value", d, exp[a]);
        end
    endtask

    // read back of count, period, control; unmapped write ignored
    task automatic rw_access();
        logic [7:0] d;
        wr(`PMT_ADDR_PERIOD, 8'h5a);
        rd(`PMT_ADDR_PERIOD, d);
        check("period", d, 8'h5a);
        wr(`PMT_ADDR_COUNT, 8'h33);
        rd(`PMT_ADDR_COUNT, d);
        check("count", d, 8'h33);
        wr(`PMT_ADDR_CONTROL, 8'hff);
        rd(`PMT_ADDR_CONTROL, d);
        check("control bit 7", d, 8'h7f);
        wr(`PMT_ADDR_CONTROL, 8'h00);
        wr(3'h6, 8'hff);
        rd(3'h6, d);
        check("unmapped", d, 8'h00);
    endtask

    // match spacing for every prescale code with period 2
    task automatic prescale_codes();
        int n;
        int div;
        wr(`PMT_ADDR_PERIOD, 8'h02);
        wr(`PMT_ADDR_COUNT, 8'h00);
        for (int p = 0; p < 4; p++) begin
            div = (p == 0) ? 1 : (p == 1) ? 4 : 16;
            wr(`PMT_ADDR_CONTROL, {5'h00, 1'b1, 2'(p)});
            wait_match(n);
            wait_match(n);
            check("match spacing", 8'(n), 8'(12 * div));
        end
    endtask

    // postscale select: flag after n+1 matches, masking and clearing
    task automatic postscale_irq();
        logic [7:0] d;
        int n;
        logic [3:0] sel [3] = '{4'h0, 4'h3, 4'hf};
        wr(`PMT_ADDR_PERIOD, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(`PMT_ADDR_CONTROL, 8'h00);
            wr(`PMT_ADDR_FLAGS, 8'h02);
            wr(`PMT_ADDR_IRQ_EN, 8'h02);
            wr(`PMT_ADDR_COUNT, 8'h00);
            wr(`PMT_ADDR_CONTROL, {1'b0, sel[i], 1'b1, 2'b00});
            n = 0;
            for (int c = 0; c < 200 && o_irq !== 1'b1; c++) begin
                @(posedge i_clk);
                #1;
                if (o_match === 1'b1) n++;
            end
            check("irq raised", {7'h00, o_irq}, 8'h01);
            check("matches per event", 8'(n), 8'(sel[i]) + 8'h01);
            wr(`PMT_ADDR_IRQ_EN, 8'h00);
            repeat (2) @(posedge i_clk);
            #1;
            check("irq masked", {7'h00, o_irq}, 8'h00);
            rd(`PMT_ADDR_FLAGS, d);
            check("flag latched", d, 8'h02);
            wr(`PMT_ADDR_CONTROL, 8'h00);
            wr(`PMT_ADDR_FLAGS, 8'h02);
            rd(`PMT_ADDR_FLAGS, d);
            check("flag cleared", d, 8'h00);
        end
    endtask

    // timer off holds the count and makes no pulses; control write keeps count
    task automatic off_hold();
        logic [7:0] d;
        int seen;
        seen = 0;
        wr(`PMT_ADDR_PERIOD, 8'h07);
        wr(`PMT_ADDR_COUNT, 8'h07);
        for (int c = 0; c < 40; c++) begin
            @(posedge i_clk);
            #1;
            if (o_match !== 1'b0) seen++;
        end
        check("pulses while off", 8'(seen), 8'h00);
        rd(`PMT_ADDR_COUNT, d);
        check("count held", d, 8'h07);
        wr(`PMT_ADDR_CONTROL, 8'h01);
        rd(`PMT_ADDR_COUNT, d);
        check("count after control write", d, 8'h07);
    endtask

    // a count or control write mid-period restarts the prescaler
    task automatic scaler_clear();
        int n;
        logic [2:0] a [2] = '{`PMT_ADDR_COUNT, `PMT_ADDR_CONTROL};
        logic [7:0] v [2] = '{8'h00, 8'h06};
        wr(`PMT_ADDR_PERIOD, 8'h00);
        wr(`PMT_ADDR_COUNT, 8'h00);
        wr(`PMT_ADDR_CONTROL, 8'h06);
        for (int i = 0; i < 2; i++) begin
            wait_match(n);
            repeat (40) @(posedge i_clk);
            wr(a[i], v[i]);
            wait_match(n);
            check("restart after write", {7'h00, n >= 60}, 8'h01);
        end
        wr(`PMT_ADDR_CONTROL, 8'h00);
    endtask

    // a device reset in mid-run restores count, period and control
    task automatic mid_reset();
        logic [7:0] d;
        wr(`PMT_ADDR_PERIOD, 8'h5a);
        wr(`PMT_ADDR_COUNT, 8'h33);
        wr(`PMT_ADDR_CONTROL, 8'h07);
        repeat (20) @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(`PMT_ADDR_COUNT, d);
        check("count after reset", d, 8'h00);
        rd(`PMT_ADDR_PERIOD, d);
        check("period after reset", d, 8'hff);
        rd(`PMT_ADDR_CONTROL, d);
        check("control after reset", d, 8'h00);
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        reset_values();
        rw_access();
        prescale_codes();
        postscale_irq();
        off_hold();
        scaler_clear();
        mid_reset();
        summarize();
    end
endmodule
